// file: include/somc_map.svh
// offsets, field positions, reset values and mode codes of the supply output mode registers
// How it works
// - Registers at 1Fh through 22h hold every output's drive configuration.
// - Output one in 1Fh[2:0]: 000..011 open-drain/push-pull, low/high active.
// - Outputs one to four: code 100 selects closed-loop tracking control.
// - Outputs one to six: code 101 charge-pump gate drive; 110, 111 reserved.
// - Output two sits in 1Fh[5:3] with output one's encoding.
// - Output three: low bits in 1Fh[7:6], top bit in 20h[0].
// - Output four sits in 20h[3:1], tracking included.
// - Output five sits in 20h[6:4]; code 100 is reserved there.
// - Output six: low bit 20h[7], upper bits 21h[1:0]; 100 reserved.
// - Outputs seven to nine use two-bit fields at 21h[3:2],[5:4],[7:6].
// - Outputs ten to twelve use 22h two-bit fields; 22h[7:6] reserved.
`ifndef SOMC_MAP_SVH
`define SOMC_MAP_SVH

//----------------------------------------------------------------
// register offsets
//----------------------------------------------------------------
`define SOMC_OFS_CFG_A 8'h1F
`define SOMC_OFS_CFG_B 8'h20
`define SOMC_OFS_CFG_C 8'h21
`define SOMC_OFS_CFG_D 8'h22

//----------------------------------------------------------------
// reset values and reserved masks
//----------------------------------------------------------------
`define SOMC_RST_CFG 8'h00
`define SOMC_MASK_CFG_D 8'h3F

//----------------------------------------------------------------
// field positions (low bit of each field)
//----------------------------------------------------------------
`define SOMC_POS_OUT1 0
`define SOMC_POS_OUT2 3
`define SOMC_POS_OUT3_LO 6
`define SOMC_POS_OUT3_HI 0
`define SOMC_POS_OUT4 1
`define SOMC_POS_OUT5 4
`define SOMC_POS_OUT6_LO 7
`define SOMC_POS_OUT6_HI 0
`define SOMC_POS_OUT7 2

//----------------------------------------------------------------
// mode codes
//----------------------------------------------------------------
`define SOMC_CODE_TRACK 3'h4
`define SOMC_CODE_PUMP 3'h5

`endif

// file: include/somc_pkg.sv
// types of the supply output mode configuration block
package somc_pkg;
   // decoded drive mode of one output
   typedef enum logic [2:0] {
      SOMC_OD_LOW,
      SOMC_OD_HIGH,
      SOMC_PP_LOW,
      SOMC_PP_HIGH,
      SOMC_TRACK,
      SOMC_PUMP,
      SOMC_RESERVED
   } somc_mode_type;

   // register write/read request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } somc_req_type;

   // pad driver control for one output
   typedef struct packed {
      logic out;
      logic oe;
   } somc_pad_type;
endpackage

// file: logic/somc_mode_decode.sv
// decoder of one output's mode code into pad drive
`timescale 1ns/100ps
`default_nettype none
`include "somc_map.svh"
module somc_mode_decode #(
   parameter bit HAS_TRACK = 1'b0,
   parameter bit HAS_PUMP = 1'b0,
   parameter bit WIDE = 1'b0
) (
   // mode field, two-bit fields sit in the low bits
   input wire logic [2:0] code,
   // enable request from the sequencer and its tracking/pump drive
   input wire logic assert_req,
   input wire logic loop_drive,
   // decoded mode and pad control
   output somc_pkg::somc_mode_type mode,
   output somc_pkg::somc_pad_type pad
);
   logic level;

   // code to mode; codes outside the output's set decode as reserved
   always_comb begin
      mode = somc_pkg::SOMC_RESERVED;
      if (!WIDE || !code[2]) begin
         mode = somc_pkg::somc_mode_type'({1'b0, code[1:0]});
      end else if (code == `SOMC_CODE_TRACK && HAS_TRACK) begin
         mode = somc_pkg::SOMC_TRACK;
      end else if (code == `SOMC_CODE_PUMP && HAS_PUMP) begin
         mode = somc_pkg::SOMC_PUMP;
      end
   end

   // drive: polarity sets asserted level, open-drain only pulls low
   always_comb begin
      level = assert_req ~^ code[0];
      pad.out = 1'b0;
      pad.oe = 1'b0;
      unique case (mode)
         somc_pkg::SOMC_OD_LOW, somc_pkg::SOMC_OD_HIGH: begin
            pad.oe = !level;
         end
         somc_pkg::SOMC_PP_LOW, somc_pkg::SOMC_PP_HIGH: begin
            pad.out = level;
            pad.oe = 1'b1;
         end
         somc_pkg::SOMC_TRACK, somc_pkg::SOMC_PUMP: begin
            pad.out = loop_drive;
            pad.oe = 1'b1;
         end
         default: begin
            pad.oe = 1'b0;
         end
      endcase
   end
endmodule
`default_nettype wire

// file: logic/somc_top.sv
// register bank and per-output mode decoding of the supply enable outputs
`timescale 1ns/100ps
`default_nettype none
`include "somc_map.svh"
module somc_top #(
   parameter int NUM_OUT = 12
) (
   // clock and reset
   input wire logic CLK,
   input wire logic RESETN,
   // register access from the serial or loader side
   input wire somc_pkg::somc_req_type REQ,
   output logic [7:0] RDATA,
   output logic RVALID,
   // per-output requests from the sequencer and analog loops
   input wire logic [NUM_OUT-1:0] ASSERT_REQ,
   input wire logic [NUM_OUT-1:0] LOOP_DRIVE,
   // pad control and decoded modes
   output logic [NUM_OUT-1:0] PAD_OUT,
   output logic [NUM_OUT-1:0] PAD_OE,
   output logic [NUM_OUT*3-1:0] MODE
);
   //----------------------------------------------------------------
   // configuration registers
   //----------------------------------------------------------------
   logic [7:0] cfg_a;
   logic [7:0] cfg_b;
   logic [7:0] cfg_c;
   logic [7:0] cfg_d;
   logic [2:0] code [12];
   logic [NUM_OUT-1:0] pad_out_c;
   logic [NUM_OUT-1:0] pad_oe_c;
   logic [NUM_OUT*3-1:0] mode_c;

   // register writes
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         cfg_a <= `SOMC_RST_CFG;
         cfg_b <= `SOMC_RST_CFG;
         cfg_c <= `SOMC_RST_CFG;
         cfg_d <= `SOMC_RST_CFG;
      end else if (REQ.wr) begin
         unique case (REQ.addr)
            `SOMC_OFS_CFG_A: cfg_a <= REQ.wdata;
            `SOMC_OFS_CFG_B: cfg_b <= REQ.wdata;
            `SOMC_OFS_CFG_C: cfg_c <= REQ.wdata;
            `SOMC_OFS_CFG_D: cfg_d <= REQ.wdata & `SOMC_MASK_CFG_D;
            default: begin
            end
         endcase
      end
   end

   // register reads, one cycle after the request; unmapped reads zero
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         RDATA <= 8'h00;
         RVALID <= 1'b0;
      end else begin
         RVALID <= REQ.rd;
         if (REQ.rd) begin
            unique case (REQ.addr)
               `SOMC_OFS_CFG_A: RDATA <= cfg_a;
               `SOMC_OFS_CFG_B: RDATA <= cfg_b;
               `SOMC_OFS_CFG_C: RDATA <= cfg_c;
               `SOMC_OFS_CFG_D: RDATA <= cfg_d;
               default: RDATA <= 8'h00;
            endcase
         end
      end
   end

   //----------------------------------------------------------------
   // field extraction
   //----------------------------------------------------------------
   always_comb begin
      code[0] = cfg_a[`SOMC_POS_OUT1 +: 3];
      code[1] = cfg_a[`SOMC_POS_OUT2 +: 3];
      code[2] = {cfg_b[`SOMC_POS_OUT3_HI], cfg_a[`SOMC_POS_OUT3_LO +: 2]};
      code[3] = cfg_b[`SOMC_POS_OUT4 +: 3];
      code[4] = cfg_b[`SOMC_POS_OUT5 +: 3];
      code[5] = {cfg_c[`SOMC_POS_OUT6_HI +: 2], cfg_b[`SOMC_POS_OUT6_LO]};
      code[6] = {1'b0, cfg_c[`SOMC_POS_OUT7 +: 2]};
      code[7] = {1'b0, cfg_c[`SOMC_POS_OUT7 + 2 +: 2]};
      code[8] = {1'b0, cfg_c[`SOMC_POS_OUT7 + 4 +: 2]};
      code[9] = {1'b0, cfg_d[1:0]};
      code[10] = {1'b0, cfg_d[3:2]};
      code[11] = {1'b0, cfg_d[5:4]};
   end

   //----------------------------------------------------------------
   // per-output decoders
   //----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
         somc_pkg::somc_mode_type m;
         somc_pkg::somc_pad_type p;
         somc_mode_decode #(
            .HAS_TRACK(gi < 4),
            .HAS_PUMP(gi < 6),
            .WIDE(gi < 6)
         ) u_dec (
            .code(code[gi]),
            .assert_req(ASSERT_REQ[gi]),
            .loop_drive(LOOP_DRIVE[gi]),
            .mode(m),
            .pad(p)
         );
         assign pad_out_c[gi] = p.out;
         assign pad_oe_c[gi] = p.oe;
         assign mode_c[gi*3 +: 3] = m;
      end
   endgenerate

   // pad and mode outputs registered
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         PAD_OUT <= '0;
         PAD_OE <= '0;
         MODE <= '0;
      end else begin
         PAD_OUT <= pad_out_c;
         PAD_OE <= pad_oe_c;
         MODE <= mode_c;
      end
   end

   //----------------------------------------------------------------
   // assertions
   //----------------------------------------------------------------
   property p_write_a;
      @(posedge CLK) disable iff (!RESETN)
      REQ.wr && REQ.addr == `SOMC_OFS_CFG_A |=> cfg_a == $past(REQ.wdata);
   endproperty
   a_write_a: assert property (p_write_a) else $error("cfg_a write lost");

   property p_read_d_reserved;
      @(posedge CLK) disable iff (!RESETN)
      REQ.rd && REQ.addr == `SOMC_OFS_CFG_D |=> RDATA[7:6] == 2'b00 && RVALID;
   endproperty
   a_read_d_reserved: assert property (p_read_d_reserved) else $error("22h reserved set");

   property p_od_low;
      @(posedge CLK) disable iff (!RESETN)
      cfg_a[2:0] == 3'h0 && ASSERT_REQ[0] |=> PAD_OE[0] && !PAD_OUT[0];
   endproperty
   a_od_low: assert property (p_od_low) else $error("out1 od low not pulling");

   property p_pp_high;
      @(posedge CLK) disable iff (!RESETN)
      cfg_a[5:3] == 3'h3 |=> PAD_OE[1] && PAD_OUT[1] == $past(ASSERT_REQ[1]);
   endproperty
   a_pp_high: assert property (p_pp_high) else $error("out2 push-pull wrong");

   property p_track4;
      @(posedge CLK) disable iff (!RESETN)
      cfg_b[3:1] == `SOMC_CODE_TRACK |=> MODE[11:9] == somc_pkg::SOMC_TRACK;
   endproperty
   a_track4: assert property (p_track4) else $error("out4 tracking not decoded");

   property p_out5_no_track;
      @(posedge CLK) disable iff (!RESETN)
      cfg_b[6:4] == `SOMC_CODE_TRACK |=> MODE[14:12] == somc_pkg::SOMC_RESERVED && !PAD_OE[4];
   endproperty
   a_out5_no_track: assert property (p_out5_no_track) else $error("out5 tracking");

   property p_out3_split;
      @(posedge CLK) disable iff (!RESETN)
      cfg_b[0] && cfg_a[7:6] == 2'b01 |=> MODE[8:6] == somc_pkg::SOMC_PUMP;
   endproperty
   a_out3_split: assert property (p_out3_split) else $error("out3 split wrong");

   property p_out6_split;
      @(posedge CLK) disable iff (!RESETN)
      cfg_c[1:0] == 2'b10 && cfg_b[7] |=> MODE[17:15] == somc_pkg::SOMC_PUMP;
   endproperty
   a_out6_split: assert property (p_out6_split) else $error("out6 split wrong");

   property p_out7_od_high;
      @(posedge CLK) disable iff (!RESETN)
      cfg_c[3:2] == 2'b01 && ASSERT_REQ[6] |=> !PAD_OE[6];
   endproperty
   a_out7_od_high: assert property (p_out7_od_high) else $error("out7 od high drives");

   property p_write_b;
      @(posedge CLK) disable iff (!RESETN)
      REQ.wr && REQ.addr == `SOMC_OFS_CFG_B |=> cfg_b == $past(REQ.wdata);
   endproperty
   a_write_b: assert property (p_write_b) else $error("cfg_b write lost");

   property p_write_c;
      @(posedge CLK) disable iff (!RESETN)
      REQ.wr && REQ.addr == `SOMC_OFS_CFG_C |=> cfg_c == $past(REQ.wdata);
   endproperty
   a_write_c: assert property (p_write_c) else $error("cfg_c write lost");

   property p_write_d;
      @(posedge CLK) disable iff (!RESETN)
      REQ.wr && REQ.addr == `SOMC_OFS_CFG_D |=> cfg_d == ($past(REQ.wdata) & `SOMC_MASK_CFG_D);
   endproperty
   a_write_d: assert property (p_write_d) else $error("cfg_d write not masked");

   property p_read_a;
      @(posedge CLK) disable iff (!RESETN)
      REQ.rd && REQ.addr == `SOMC_OFS_CFG_A |=> RVALID && RDATA == $past(cfg_a);
   endproperty
   a_read_a: assert property (p_read_a) else $error("cfg_a read wrong");

   property p_read_unmapped;
      @(posedge CLK) disable iff (!RESETN)
      REQ.rd && (REQ.addr < `SOMC_OFS_CFG_A || REQ.addr > `SOMC_OFS_CFG_D) |=> RDATA == 8'h00;
   endproperty
   a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read not zero");

   property p_rvalid_pulse;
      @(posedge CLK) disable iff (!RESETN)
      !REQ.rd |=> !RVALID;
   endproperty
   a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read valid without read");

   property p_unmapped_write;
      @(posedge CLK) disable iff (!RESETN)
      REQ.wr && REQ.addr > `SOMC_OFS_CFG_D |=> $stable({cfg_a, cfg_b, cfg_c, cfg_d});
   endproperty
   a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write landed");

   property p_out1_pp_low;
      @(posedge CLK) disable iff (!RESETN)
      cfg_a[2:0] == 3'h2 |=> PAD_OE[0] && PAD_OUT[0] == !$past(ASSERT_REQ[0]);
   endproperty
   a_out1_pp_low: assert property (p_out1_pp_low) else $error("out1 push-pull low wrong");

   property p_out1_track;
      @(posedge CLK) disable iff (!RESETN)
      cfg_a[2:0] == `SOMC_CODE_TRACK |=> MODE[2:0] == somc_pkg::SOMC_TRACK && PAD_OE[0];
   endproperty
   a_out1_track: assert property (p_out1_track) else $error("out1 tracking not decoded");

   property p_out2_pump;
      @(posedge CLK) disable iff (!RESETN)
      cfg_a[5:3] == `SOMC_CODE_PUMP |=> PAD_OE[1] && PAD_OUT[1] == $past(LOOP_DRIVE[1]);
   endproperty
   a_out2_pump: assert property (p_out2_pump) else $error("out2 pump drive wrong");

   property p_out1_reserved;
      @(posedge CLK) disable iff (!RESETN)
      cfg_a[2:1] == 2'b11 |=> MODE[2:0] == somc_pkg::SOMC_RESERVED && !PAD_OE[0];
   endproperty
   a_out1_reserved: assert property (p_out1_reserved) else $error("out1 reserved drives");

   property p_out3_track;
      @(posedge CLK) disable iff (!RESETN)
      {cfg_b[0], cfg_a[7:6]} == `SOMC_CODE_TRACK |=> MODE[8:6] == somc_pkg::SOMC_TRACK;
   endproperty
   a_out3_track: assert property (p_out3_track) else $error("out3 tracking not decoded");

   property p_out4_pump;
      @(posedge CLK) disable iff (!RESETN)
      cfg_b[3:1] == `SOMC_CODE_PUMP |=> MODE[11:9] == somc_pkg::SOMC_PUMP;
   endproperty
   a_out4_pump: assert property (p_out4_pump) else $error("out4 pump not decoded");

   property p_out5_pump;
      @(posedge CLK) disable iff (!RESETN)
      cfg_b[6:4] == `SOMC_CODE_PUMP |=> MODE[14:12] == somc_pkg::SOMC_PUMP && PAD_OE[4];
   endproperty
   a_out5_pump: assert property (p_out5_pump) else $error("out5 pump not decoded");

   property p_out6_no_track;
      @(posedge CLK) disable iff (!RESETN)
      {cfg_c[1:0], cfg_b[7]} == `SOMC_CODE_TRACK |=> MODE[17:15] == somc_pkg::SOMC_RESERVED;
   endproperty
   a_out6_no_track: assert property (p_out6_no_track) else $error("out6 tracking");

   property p_out8_pp_low;
      @(posedge CLK) disable iff (!RESETN)
      cfg_c[5:4] == 2'b10 |=> PAD_OE[7] && PAD_OUT[7] == !$past(ASSERT_REQ[7]);
   endproperty
   a_out8_pp_low: assert property (p_out8_pp_low) else $error("out8 push-pull low wrong");

   property p_out9_pp_high;
      @(posedge CLK) disable iff (!RESETN)
      cfg_c[7:6] == 2'b11 |=> MODE[26:24] == somc_pkg::SOMC_PP_HIGH;
   endproperty
   a_out9_pp_high: assert property (p_out9_pp_high) else $error("out9 mode wrong");

   property p_out10_od_low;
      @(posedge CLK) disable iff (!RESETN)
      cfg_d[1:0] == 2'b00 && ASSERT_REQ[9] |=> PAD_OE[9] && !PAD_OUT[9];
   endproperty
   a_out10_od_low: assert property (p_out10_od_low) else $error("out10 od low not pulling");

   property p_out12_pp_high;
      @(posedge CLK) disable iff (!RESETN)
      cfg_d[5:4] == 2'b11 |=> PAD_OE[11] && PAD_OUT[11] == $past(ASSERT_REQ[11]);
   endproperty
   a_out12_pp_high: assert property (p_out12_pp_high) else $error("out12 push-pull wrong");

   property p_od_float;
      @(posedge CLK) disable iff (!RESETN)
      cfg_c[3:2] == 2'b00 && !ASSERT_REQ[6] |=> !PAD_OE[6] && !PAD_OUT[6];
   endproperty
   a_od_float: assert property (p_od_float) else $error("out7 open-drain not floating");

   c_track: cover property (@(posedge CLK) MODE[2:0] == somc_pkg::SOMC_TRACK);
   c_pump: cover property (@(posedge CLK) MODE[17:15] == somc_pkg::SOMC_PUMP);
   c_reserved: cover property (@(posedge CLK) MODE[14:12] == somc_pkg::SOMC_RESERVED);
   c_out12_pp: cover property (@(posedge CLK) PAD_OE[11] && MODE[35:33] == somc_pkg::SOMC_PP_HIGH);
   c_read_back: cover property (@(posedge CLK) RVALID && RDATA != 8'h00);
endmodule
`default_nettype wire

// file: verification/somc_supply_load.sv
// model of the supply enable inputs hanging on the pads
`timescale 1ns/100ps
`default_nettype none
module somc_supply_load #(
   parameter int NUM_OUT = 12
) (
   // pad drive from the block
   input wire logic [NUM_OUT-1:0] pad_out,
   input wire logic [NUM_OUT-1:0] pad_oe,
   // level seen by the supply enable pins
   output logic [NUM_OUT-1:0] line
);
   // an undriven pad is lifted by the external pull-up resistor
   always_comb begin
      for (int i = 0; i < NUM_OUT; i++) begin
         line[i] = pad_oe[i] ? pad_out[i] : 1'b1;
      end
   end
endmodule
`default_nettype wire

// file: verification/tb.sv
// self-checking testbench of the supply output mode register bank
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic clk;
   logic resetn;
   somc_pkg::somc_req_type req;
   logic [7:0] rdata;
   logic rvalid;
   logic [11:0] assert_req;
   logic [11:0] loop_drive;
   logic [11:0] pad_out;
   logic [11:0] pad_oe;
   logic [11:0] line;
   logic [35:0] mode;
   logic [7:0] exp_q[$];
   logic [7:0] cfg[4];
   logic [29:0] v;
   int num_errors;
   int n_checks;

   somc_top u_dut (.CLK(clk), .RESETN(resetn), .REQ(req), .RDATA(rdata), .RVALID(rvalid),
      .ASSERT_REQ(assert_req), .LOOP_DRIVE(loop_drive), .PAD_OUT(pad_out), .PAD_OE(pad_oe),
      .MODE(mode));
   somc_supply_load u_load (.pad_out(pad_out), .pad_oe(pad_oe), .line(line));

   //----------------------------------------------------------------
   // helpers
   //----------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
      req <= '{wr: w, rd: r, addr: a, wdata: d};
      @(posedge clk);
   endtask

   task automatic report_and_stop();
      if (num_errors == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // expected decoded mode of output i for field value c
   function automatic logic [2:0] emode(input int i, input logic [2:0] c);
      if (i > 5 || c < 3'h4) return c;
      if (c == 3'h4 && i < 4) return 3'(somc_pkg::SOMC_TRACK);
      if (c == 3'h5) return 3'(somc_pkg::SOMC_PUMP);
      return 3'(somc_pkg::SOMC_RESERVED);
   endfunction

   //----------------------------------------------------------------
   // clock, watchdog and read monitor
   //----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial begin
      #300us;
      num_errors++;
      report_and_stop();
   end

   // each read answer is matched against the oldest noted value
   always @(negedge clk) begin
      if (rvalid === 1'b1) begin
         if (exp_q.size() == 0) chk(8'hEE, 8'h00, "unexpected read");
         else chk(rdata, exp_q.pop_front(), "read data");
      end
   end

   //----------------------------------------------------------------
   // main sequence
   //----------------------------------------------------------------
   initial begin
      logic [2:0] c;
      logic [2:0] m;
      logic lvl;
      req = '0;
      assert_req = 12'h000;
      loop_drive = 12'h000;
      resetn = 1'b0;
      void'($urandom(32'h0C66));
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      // reset values, unmapped write ignored and unmapped read zero
      acc(1'b1, 1'b0, 8'h23, 8'hFF);
      for (int a = 8'h1F; a <= 8'h23; a++) begin
         exp_q.push_back(8'h00);
         acc(1'b0, 1'b1, 8'(a), 8'h00);
      end
      for (int n = 0; n < 60; n++) begin
         for (int k = 0; k < 4; k++) cfg[k] = 8'($urandom());
         assert_req <= 12'($urandom());
         loop_drive <= 12'($urandom());
         // back-to-back writes then read-back of every register
         for (int k = 0; k < 4; k++) acc(1'b1, 1'b0, 8'h1F + 8'(k), cfg[k]);
         for (int k = 0; k < 4; k++) begin
            exp_q.push_back(k == 3 ? (cfg[3] & 8'h3F) : cfg[k]);
            acc(1'b0, 1'b1, 8'h1F + 8'(k), 8'h00);
         end
         acc(1'b0, 1'b0, 8'h00, 8'h00);
         repeat (2) @(posedge clk);
         #1;
         v = {cfg[3][5:0], cfg[2], cfg[1], cfg[0]};
         for (int i = 0; i < 12; i++) begin
            c = (i < 6) ? v[3*i +: 3] : {1'b0, v[18 + 2*(i-6) +: 2]};
            m = emode(i, c);
            lvl = assert_req[i] ~^ m[0];
            chk(8'(mode[3*i +: 3]), 8'(m), "decoded mode");
            chk(8'(pad_oe[i]), 8'(m < 3'h2 ? !lvl : m < 3'h6), "pad enable");
            chk(8'(line[i]), 8'(m < 3'h4 ? lvl : m < 3'h6 ? loop_drive[i] : 1'b1), "pad level");
         end
      end
      chk(8'(exp_q.size()), 8'h00, "missing read answers");
      report_and_stop();
   end
endmodule
`default_nettype wire
